// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import fbr_pkg::*;
  ;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  fbr_host_s        host_i;
  logic [7:0]       rdata_o;
  logic             rvalid_o;
  logic [1:0]       modem_control_prescale_i;
  logic [1:0]       enhanced_mode_x16_i;
  logic             osc = 1'b0;
  logic             osc_en = 1'b0;
  logic             oscillator_output_o;
  logic [1:0]       sample_tick_o;
  logic [1:0]       bit_tick_o;
  int               n_fail = 0;
  int               n_checks = 0;

  fbr_top fbr_top_i (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .host_i                   (host_i),
    .rdata_o                  (rdata_o),
    .rvalid_o                 (rvalid_o),
    .modem_control_prescale_i (modem_control_prescale_i),
    .enhanced_mode_x16_i      (enhanced_mode_x16_i),
    .oscillator_input_i       (osc),
    .oscillator_output_o      (oscillator_output_o),
    .sample_tick_o            (sample_tick_o),
    .bit_tick_o               (bit_tick_o)
  );

  always #10 clk_i = ~clk_i;
  // oscillator period is 8 clk, offset so edges never meet the clock edge
  initial begin
    #3;
    forever #80 if (osc_en) osc = ~osc;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] cs, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    host_i = '{wr: 1'b1, rd: 1'b0, cs_n: cs, addr: a, wdata: d};
    @(negedge clk_i);
    host_i.wr = 1'b0;
    host_i.cs_n = 2'h3;
  endtask

  task automatic rd(input logic [1:0] cs, input logic [1:0] a, input logic [7:0] e);
    @(negedge clk_i);
    host_i = '{wr: 1'b0, rd: 1'b1, cs_n: cs, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    chk(rvalid_o, 1'b1);
    chk(rdata_o, e);
    host_i.rd = 1'b0;
    host_i.cs_n = 2'h3;
    @(negedge clk_i);
    chk(rvalid_o, 1'b0);
  endtask

  // a starved generator must stay silent on both tick outputs
  task automatic t_quiet(input int ch, input int cycles);
    int nt;
    int nb;
    nt = 0;
    nb = 0;
    repeat (cycles) begin
      @(negedge clk_i);
      if (sample_tick_o[ch] !== 1'b0) nt++;
      if (bit_tick_o[ch] !== 1'b0) nb++;
    end
    chk(nt, 0);
    chk(nb, 0);
  endtask

  // two ticks are skipped first so a divisor change mid-period is not measured
  task automatic meas(input int ch, input int n, input int exp, input int bits);
    int k;
    int cyc;
    int nb;
    k = 0;
    cyc = 0;
    nb = 0;
    while (k < 2 && cyc < 20000) begin
      @(negedge clk_i);
      cyc++;
      if (sample_tick_o[ch] === 1'b1) k++;
    end
    k = 0;
    cyc = 0;
    while (k < n && cyc < 70000) begin
      @(negedge clk_i);
      cyc++;
      if (sample_tick_o[ch] === 1'b1) k++;
      if (bit_tick_o[ch] === 1'b1) nb++;
    end
    chk(cyc, exp);
    if (bits >= 0) chk(nb, bits);
  endtask

  task automatic t_reset();
    rd(2'b10, FBR_SEL_LOW, 8'h01);
    rd(2'b10, FBR_SEL_HIGH, 8'h00);
    rd(2'b01, FBR_SEL_LOW, 8'h01);
    rd(2'b01, FBR_SEL_FRAC, 8'h00);
  endtask

  task automatic t_regs();
    wr(2'b00, FBR_SEL_LOW, 8'h05);
    rd(2'b01, FBR_SEL_LOW, 8'h05);
    wr(2'b01, FBR_SEL_HIGH, 8'ha6);
    rd(2'b01, FBR_SEL_HIGH, 8'ha6);
    rd(2'b10, FBR_SEL_HIGH, 8'h00);
    wr(2'b10, FBR_SEL_FRAC, 8'hfb);
    rd(2'b10, FBR_SEL_FRAC, 8'h0b);
    wr(2'b10, 2'h3, 8'h77);
    rd(2'b10, 2'h3, 8'h00);
  endtask

  // expected span of n sampling ticks, in clk cycles, from the rate rules
  task automatic rate(input int ch, input logic p, input logic m, input logic [7:0] h,
                      input logic [7:0] l, input logic [3:0] f, input int n, input int bits);
    logic [1:0] cs;
    int         e;
    cs = (ch == 0) ? 2'b10 : 2'b01;
    modem_control_prescale_i[ch] = p;
    enhanced_mode_x16_i[ch] = m;
    wr(cs, FBR_SEL_HIGH, h);
    wr(cs, FBR_SEL_LOW, l);
    wr(cs, FBR_SEL_FRAC, {4'h0, f});
    e = (n * {h, l} + ((n == 16) ? f : 0)) * 8 * (p ? 4 : 1);
    meas(ch, n, e, bits);
  endtask

  initial begin
    host_i = '{wr: 1'b0, rd: 1'b0, cs_n: 2'h3, addr: 2'h0, wdata: 8'h00};
    modem_control_prescale_i = 2'h0;
    enhanced_mode_x16_i = 2'h0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_regs();
    // oscillator still stopped: pin idles high, no ticks at all
    chk(oscillator_output_o, 1'b1);
    t_quiet(0, 200);
    osc_en = 1'b1;
    rate(0, 1'b0, 1'b0, 8'h00, 8'h01, 4'h0, 16, 2);
    rate(0, 1'b0, 1'b1, 8'h00, 8'h02, 4'h0, 16, 1);
    rate(0, 1'b0, 1'b0, 8'h00, 8'h02, 4'h5, 16, 2);
    rate(1, 1'b1, 1'b1, 8'h00, 8'h03, 4'h0, 16, 1);
    meas(0, 16, 296, 2);
    rate(1, 1'b0, 1'b1, 8'h01, 8'h00, 4'h0, 2, -1);
    wr(2'b01, FBR_SEL_HIGH, 8'h00);
    wr(2'b01, FBR_SEL_LOW, 8'h00);
    t_quiet(1, 300);
    end_sim();
  end

  // about 12000 cycles expected; allow a wide margin
  initial begin
    #600000;
    n_fail++;
    end_sim();
  end
endmodule

// *** logic/fbr_chan.sv ***
`timescale 1ns/1ps
module fbr_chan
  import fbr_pkg::*;
(
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // clock source and mode
  input  wire logic     osc_tick_i,
  input  wire logic     div4_i,
  input  wire logic     sample16_i,
  input  wire fbr_div_s div_i,
  // sampling outputs
  output logic          sample_tick_o,
  output logic          bit_tick_o
);

  logic [1:0]           pre_cnt_r;
  logic                 pre_tick;
  logic [FBR_INT_W-1:0] int_div;
  logic [FBR_INT_W:0]   div_cnt_r;
  logic [FBR_INT_W:0]   period_m1;
  logic                 sample_hit;
  logic [FBR_FRAC_W-1:0] acc_r;
  logic                 stretch_r;
  logic [3:0]           bit_cnt_r;
  logic [3:0]           bit_last;

  assign pre_tick = osc_tick_i && (!div4_i || pre_cnt_r == FBR_PRE_LAST); // RULE_01

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_r <= 2'h0;
    end else if (!div4_i) begin
      pre_cnt_r <= 2'h0;
    end else if (osc_tick_i) begin
      pre_cnt_r <= pre_cnt_r + 2'h1; // RULE_01
    end
  end

  assign int_div    = {div_i.high, div_i.low}; // RULE_06
  // stretched period is int_div plus one prescaled cycle
  assign period_m1  = {1'b0, int_div} + {{FBR_INT_W{1'b0}}, stretch_r} - 17'h0_0001; // RULE_13
  // a zero divisor stalls the generator rather than wrapping
  assign sample_hit = pre_tick && (int_div != '0) && (div_cnt_r >= period_m1); // RULE_02

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_r <= '0;
    end else if (pre_tick) begin
      if (sample_hit || int_div == '0) begin
        div_cnt_r <= '0;
      end else begin
        div_cnt_r <= div_cnt_r + 17'h0_0001; // RULE_02
      end
    end
  end

  // carry of the fraction accumulator stretches the next period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r     <= '0;
      stretch_r <= 1'b0;
    end else if (sample_hit) begin
      {stretch_r, acc_r} <= {1'b0, acc_r} + {1'b0, div_i.frac}; // RULE_07 RULE_13 RULE_08
    end
  end

  assign bit_last = sample16_i ? FBR_X16_LAST : FBR_X8_LAST; // RULE_04

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_r     <= 4'h0;
      sample_tick_o <= 1'b0;
      bit_tick_o    <= 1'b0;
    end else begin
      sample_tick_o <= sample_hit; // RULE_03
      bit_tick_o    <= sample_hit && bit_cnt_r >= bit_last; // RULE_03
      if (sample_hit) begin
        bit_cnt_r <= (bit_cnt_r >= bit_last) ? 4'h0 : bit_cnt_r + 4'h1; // RULE_04
      end
    end
  end

  // helper logic for the checks below
  logic [FBR_INT_W:0] gap_r;
  logic               stable_r;
  logic [3:0]         seen_r;
  logic               bit_ok_r;
  logic [2:0]         osc_gap_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r     <= '0;
      stable_r  <= 1'b0;
      seen_r    <= 4'h0;
      bit_ok_r  <= 1'b0;
      osc_gap_r <= 3'h0;
    end else begin
      if (sample_hit) begin
        gap_r <= '0;
      end else if (pre_tick) begin
        gap_r <= gap_r + 17'h0_0001;
      end
      if (sample_hit) begin
        stable_r <= 1'b1;
      end else if (div_i != $past(div_i) || sample16_i != $past(sample16_i)) begin
        stable_r <= 1'b0;
      end
      // counts emitted ticks, kept apart from the internal bit counter
      if (sample_tick_o) begin
        seen_r <= bit_tick_o ? 4'h0 : seen_r + 4'h1;
      end
      // a mode switch mid-bit leaves one short bit; only whole bits are judged
      if (bit_tick_o) begin
        bit_ok_r <= 1'b1;
      end else if (sample16_i != $past(sample16_i)) begin
        bit_ok_r <= 1'b0;
      end
      if (!div4_i || pre_tick) begin
        osc_gap_r <= 3'h0;
      end else if (osc_tick_i) begin
        osc_gap_r <= osc_gap_r + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  prescale_four_a: assert property (div4_i && pre_tick |-> osc_gap_r == 3'h3) // RULE_01
    else $error("prescaler tick without four oscillator edges");
  sample_period_a: assert property (sample_hit && stable_r |-> gap_r == period_m1) // RULE_13
    else $error("sampling period differs from divisor");
  bit_ticks_a: assert property (bit_tick_o && bit_ok_r && $stable(sample16_i) // RULE_04
      |-> seen_r == bit_last)
    else $error("bit tick after wrong sample count");
  zero_stall_a: assert property (int_div == '0 |=> !sample_tick_o) // RULE_02
    else $error("sample tick with zero divisor");

  stretch_c: cover property (sample_hit && stretch_r);
  bit16_c:   cover property (bit_tick_o && sample16_i);
  div4_c:    cover property (sample_hit && div4_i);

endmodule

// *** logic/fbr_pkg.sv ***
package fbr_pkg;

  // register selectors on the host address lines
  localparam logic [1:0] FBR_SEL_LOW  = 2'h0;
  localparam logic [1:0] FBR_SEL_HIGH = 2'h1;
  localparam logic [1:0] FBR_SEL_FRAC = 2'h2;

  // reset values, overall divisor of one
  localparam logic [7:0] FBR_LOW_RST  = 8'h01;
  localparam logic [7:0] FBR_HIGH_RST = 8'h00;
  localparam logic [3:0] FBR_FRAC_RST = 4'h0;

  // field layout
  localparam int         FBR_FRAC_W    = 4;
  localparam int         FBR_INT_W     = 16;
  localparam int         FBR_CHANNELS  = 2;
  localparam int         FBR_MODE_BIT  = 7;

  // prescaler and sampling counts
  localparam logic [1:0] FBR_PRE_LAST  = 2'h3;
  localparam logic [3:0] FBR_X16_LAST  = 4'hf;
  localparam logic [3:0] FBR_X8_LAST   = 4'h7;

  typedef struct packed {
    logic [7:0]            high;
    logic [7:0]            low;
    logic [FBR_FRAC_W-1:0] frac;
  } fbr_div_s;

  localparam fbr_div_s FBR_DIV_RST = '{high: FBR_HIGH_RST, low: FBR_LOW_RST, frac: FBR_FRAC_RST};

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [FBR_CHANNELS-1:0] cs_n;
    logic [1:0]              addr;
    logic [7:0]              wdata;
  } fbr_host_s;

endpackage

// *** logic/fbr_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: input clock passes a prescaler dividing by one, or by four when selected.
// RULE_02: prescaled clock is divided by one up to 65535.9375 in sixteenth steps.
// RULE_03: divided clock is the sampling tick for transmit shifting and receive sampling.
// RULE_04: sixteen ticks per bit when the mode bit is one, eight otherwise.
// RULE_05: reset loads low byte one, high byte and fraction zero.
// RULE_06: integer divisor is high byte over low byte.
// RULE_07: only four fraction bits exist; they add code over sixteen.
// RULE_08: eight-tick mode with odd fraction may jitter by one sixteenth.
// RULE_09: register reads and writes work with the oscillator stopped.
// RULE_10: each channel has its own prescaler and divider from the shared clock.
// RULE_11: software must program the divisor at start-up; one is not useful.
// RULE_12: software rounds fraction times sixteen and splits integer into bytes.
// RULE_13: fraction realised by stretching chosen periods by one prescaled cycle.
module fbr_top
  import fbr_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // host register port
  input  wire fbr_host_s               host_i,
  output logic [7:0]                   rdata_o,
  output logic                         rvalid_o,
  // mode bits per channel
  input  wire logic [FBR_CHANNELS-1:0] modem_control_prescale_i,
  input  wire logic [FBR_CHANNELS-1:0] enhanced_mode_x16_i,
  // oscillator pins
  input  wire logic                    oscillator_input_i,
  output logic                         oscillator_output_o,
  // sampling outputs
  output logic [FBR_CHANNELS-1:0]      sample_tick_o,
  output logic [FBR_CHANNELS-1:0]      bit_tick_o
);

  function automatic logic fbr_hit(input logic cs_n, input logic [1:0] addr,
                                   input logic [1:0] sel);
    fbr_hit = !cs_n && addr == sel;
  endfunction

  // oscillator is asynchronous to the host clock
  logic osc_meta_r;
  logic osc_sync_r;
  logic osc_dly_r;
  logic osc_tick;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_meta_r          <= 1'b0;
      osc_sync_r          <= 1'b0;
      osc_dly_r           <= 1'b0;
      oscillator_output_o <= 1'b1;
    end else begin
      osc_meta_r          <= oscillator_input_i;
      osc_sync_r          <= osc_meta_r;
      osc_dly_r           <= osc_sync_r;
      oscillator_output_o <= !osc_sync_r;
    end
  end

  assign osc_tick = osc_sync_r && !osc_dly_r;

  fbr_div_s div_r [FBR_CHANNELS];

  // register file runs on the host clock only, never on the oscillator
  genvar ch;
  generate
    for (ch = 0; ch < FBR_CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          div_r[ch] <= FBR_DIV_RST; // RULE_05
        end else if (host_i.wr) begin
          // both selects low writes both channels at once
          if (fbr_hit(host_i.cs_n[ch], host_i.addr, FBR_SEL_LOW)) begin
            div_r[ch].low <= host_i.wdata; // RULE_09
          end
          if (fbr_hit(host_i.cs_n[ch], host_i.addr, FBR_SEL_HIGH)) begin
            div_r[ch].high <= host_i.wdata; // RULE_09
          end
          if (fbr_hit(host_i.cs_n[ch], host_i.addr, FBR_SEL_FRAC)) begin
            div_r[ch].frac <= host_i.wdata[FBR_FRAC_W-1:0]; // RULE_07
          end
        end
      end

      fbr_chan u_chan (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .osc_tick_i    (osc_tick), // RULE_10
        .div4_i        (modem_control_prescale_i[ch]),
        .sample16_i    (enhanced_mode_x16_i[ch]),
        .div_i         (div_r[ch]),
        .sample_tick_o (sample_tick_o[ch]),
        .bit_tick_o    (bit_tick_o[ch])
      );
    end
  endgenerate

  // read mux; channel zero wins if both are selected, which software avoids
  logic     rd_ch;
  fbr_div_s rd_div;
  assign rd_ch  = host_i.cs_n[0];
  assign rd_div = div_r[rd_ch];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= host_i.rd && !(&host_i.cs_n);
      if (host_i.rd && !(&host_i.cs_n)) begin
        case (host_i.addr)
          FBR_SEL_LOW:  rdata_o <= rd_div.low; // RULE_09
          FBR_SEL_HIGH: rdata_o <= rd_div.high; // RULE_09
          FBR_SEL_FRAC: rdata_o <= {{(8-FBR_FRAC_W){1'b0}}, rd_div.frac}; // RULE_07
          default:      rdata_o <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_value_a: assert property ($past(rst_i) |-> div_r[0] == FBR_DIV_RST && div_r[1] == FBR_DIV_RST) // RULE_05
    else $error("divisor not one after reset");
  write_low_a: assert property (host_i.wr && fbr_hit(host_i.cs_n[1], host_i.addr, FBR_SEL_LOW)
      |=> div_r[1].low == $past(host_i.wdata)) // RULE_09
    else $error("low byte write lost");
  frac_upper_a: assert property (host_i.rd && !host_i.cs_n[0] && host_i.addr == FBR_SEL_FRAC
      |=> rvalid_o && rdata_o[7:FBR_FRAC_W] == '0) // RULE_07
    else $error("fraction upper bits not zero");
  read_high_a: assert property (host_i.rd && !host_i.cs_n[0] && host_i.addr == FBR_SEL_HIGH
      |=> rdata_o == $past(div_r[0].high)) // RULE_06
    else $error("high byte read wrong");
  unmapped_a: assert property (host_i.rd && !(&host_i.cs_n) && host_i.addr == 2'h3
      |=> rdata_o == 8'h00) // RULE_09
    else $error("unmapped read not zero");

  both_write_c: cover property (host_i.wr && host_i.cs_n == 2'b00);
  two_chan_c:   cover property (sample_tick_o[0] && sample_tick_o[1]);

endmodule
